// File: hw/fmr_pkg.sv
// ----------------------------------------------------------------
// Shared constants of the multiply and reciprocal unit
// ----------------------------------------------------------------
package fmr_pkg;
  // Register byte addresses on the Avalon slave
  localparam int          FMR_AW         = 6;
  localparam logic [5:0]  FMR_ADR_J_LO   = 6'h00;
  localparam logic [5:0]  FMR_ADR_J_HI   = 6'h04;
  localparam logic [5:0]  FMR_ADR_K_LO   = 6'h08;
  localparam logic [5:0]  FMR_ADR_K_HI   = 6'h0c;
  localparam logic [5:0]  FMR_ADR_CMD    = 6'h10;
  localparam logic [5:0]  FMR_ADR_CTRL   = 6'h14;
  localparam logic [5:0]  FMR_ADR_STATUS = 6'h18;
  localparam logic [5:0]  FMR_ADR_RES_LO = 6'h1c;
  localparam logic [5:0]  FMR_ADR_RES_HI = 6'h20;
  localparam logic [5:0]  FMR_ADR_POP    = 6'h24;
  // Field positions
  localparam int          FMR_CMD_POP    = 9;
  localparam int          FMR_CTRL_IE    = 0;
  localparam int          FMR_ST_FPERR   = 1;
  // Opcodes (octal 064..067, 070, 160..167, 174)
  localparam logic [8:0]  FMR_OP_S_MUL_LO = 9'h034;
  localparam logic [8:0]  FMR_OP_S_MUL_HI = 9'h037;
  localparam logic [8:0]  FMR_OP_S_RECIP  = 9'h038;
  localparam logic [8:0]  FMR_OP_V_MUL_LO = 9'h070;
  localparam logic [8:0]  FMR_OP_V_IMUL   = 9'h076;
  localparam logic [8:0]  FMR_OP_V_MUL_HI = 9'h077;
  localparam logic [8:0]  FMR_OP_V_RECIP  = 9'h07c;
  // Multiply modes
  localparam logic [1:0]  FMR_MODE_FULL  = 2'h0;
  localparam logic [1:0]  FMR_MODE_HALF  = 2'h1;
  localparam logic [1:0]  FMR_MODE_ROUND = 2'h2;
  localparam logic [1:0]  FMR_MODE_ITER  = 2'h3;
  // Exponent limits (octal 40000, 60000, 17777)
  localparam logic [16:0] FMR_EXP_BIAS   = 17'h04000;
  localparam logic [14:0] FMR_EXP_OVF    = 15'h6000;
  localparam logic [14:0] FMR_EXP_UNF    = 15'h1fff;
  localparam logic [14:0] FMR_EXP_LOW    = 15'h2000;
  // Rounding and iteration constants of the product sum; truncation, reciprocal and reset constants
  localparam logic [95:0] FMR_RND_HALF   = 96'h3 << 64;
  localparam logic [95:0] FMR_RND_WEAK   = 96'h3 << 45;
  localparam logic [95:0] FMR_ITER_ONES  = 96'h7fff_ffff_ffff;
  localparam logic [47:0] FMR_TRUNC_MASK = 48'hffff_fff8_0000;
  localparam logic [14:0] FMR_RCP_EXP_ADJ = 15'h2;
  localparam logic        FMR_WREQ_RST   = 1'b1;
  // Control states
  typedef enum logic [1:0]
  {
    FMR_IDLE  = 2'b00,
    FMR_MUL   = 2'b01,
    FMR_RECIP = 2'b10
  } fmr_state_type;
endpackage : fmr_pkg

// File: hw/fmr_rcp_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Link between the control core and the reciprocal pipeline
// ----------------------------------------------------------------
interface fmr_rcp_if;
  logic        start;
  logic        pop;
  logic [63:0] operand;
  logic        done;
  logic [63:0] result;
  logic [6:0]  pop_count;
  logic        range_err;
  modport core (output start, pop, operand, input done, result, pop_count, range_err);
  modport unit (input start, pop, operand, output done, result, pop_count, range_err);
endinterface : fmr_rcp_if

// File: hw/fmr_recip.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Three-stage reciprocal approximation pipeline
// ----------------------------------------------------------------
module fmr_recip (
  input wire logic clock,
  input wire logic reset,
  fmr_rcp_if.unit  rif
);
  import fmr_pkg::*;

  typedef struct packed {
    logic        v1, v2, v3, p1, p2, p3, s1, s2, r1, r2, r3;
    logic [14:0] e1, e2;
    logic [41:0] b1, a1, b2, a1d, sq2;
    logic [6:0]  pc1, pc2, pc3;
    logic [63:0] res3;
  } fmr_rcp_type;

  fmr_rcp_type rcp_ff;
  fmr_rcp_type nxt_rcp;
  logic [14:0] exp_inv;

  // Radix-4 Booth product of two Q2.40 values
  function automatic logic [83:0] booth_mul(input logic [41:0] x, input logic [41:0] y);
    logic [44:0] yr;
    logic [87:0] acc;
    logic [87:0] pp;
    yr  = {2'b00, y, 1'b0};
    acc = '0;
    for (int i = 0; i < 22; i++)
    begin
      case (yr[2*i +: 3])
        3'b001, 3'b010: pp = {46'h0, x};
        3'b011:         pp = {45'h0, x, 1'b0};
        3'b100:         pp = -{45'h0, x, 1'b0};
        3'b101, 3'b110: pp = -{46'h0, x};
        default:        pp = '0;
      endcase
      acc = acc + (pp << (2 * i));
    end
    return acc[83:0];
  endfunction : booth_mul

  function automatic logic [41:0] mulq(input logic [41:0] x, input logic [41:0] y);
    logic [83:0] p;
    p = booth_mul(x, y);
    return p[81:40];
  endfunction : mulq

  // Seed: tangent of 1/b at the middle of each eighth of [1,2); never above 1/b
  // and good to about 8 bits, so two steps leave room for a 29-bit quotient
  function automatic logic [41:0] seed(input logic [2:0] idx, input logic [41:0] b);
    logic [31:0] cc;
    case (idx)
      3'h0:    cc = 32'he1e2_e2c5;
      3'h1:    cc = 32'haf28_b58a;
      3'h2:    cc = 32'h8618_949c;
      3'h3:    cc = 32'h642d_7be3;
      3'h4:    cc = 32'h47ae_68dc;
      3'h5:    cc = 32'h2f68_59e6;
      3'h6:    cc = 32'h1a7c_4ded;
      default: cc = 32'h0842_4432;
    endcase
    return {2'b01, cc[31:16], 24'h0} - mulq({2'b00, cc[15:0], 24'h0}, b);
  endfunction : seed

  assign exp_inv = ~rif.operand[62:48] + FMR_RCP_EXP_ADJ;

  // Pipeline stages
  always_comb
  begin
    logic [41:0] a0;
    logic [41:0] a2;
    a0      = '0;
    a2      = '0;
    nxt_rcp = rcp_ff;
    // First stage: exponent, range, seed, first iteration, pop
    nxt_rcp.v1  = rif.start;
    nxt_rcp.p1  = rif.pop;
    nxt_rcp.pc1 = 7'($countones(rif.operand));
    nxt_rcp.s1  = rif.operand[63];
    nxt_rcp.e1  = exp_inv;
    nxt_rcp.r1  = !rif.operand[47] || rif.operand[62:48] < FMR_EXP_LOW
                  || rif.operand[62:48] >= FMR_EXP_OVF;
    nxt_rcp.b1  = {2'b01, rif.operand[46:7]};
    a0          = seed(rif.operand[46:44], nxt_rcp.b1);
    nxt_rcp.a1  = (a0 << 1) - mulq(mulq(a0, a0), nxt_rcp.b1);
    // Second stage: square, delay operand, pre-sum twice A1
    nxt_rcp.v2  = rcp_ff.v1;
    nxt_rcp.p2  = rcp_ff.p1;
    nxt_rcp.pc2 = rcp_ff.pc1;
    nxt_rcp.s2  = rcp_ff.s1;
    nxt_rcp.e2  = rcp_ff.e1;
    nxt_rcp.r2  = rcp_ff.r1;
    nxt_rcp.sq2 = mulq(rcp_ff.a1, rcp_ff.a1);
    nxt_rcp.b2  = rcp_ff.b1;
    nxt_rcp.a1d = rcp_ff.a1 << 1;
    // Final stage: second iteration, zero during pop
    nxt_rcp.v3  = rcp_ff.v2;
    nxt_rcp.p3  = rcp_ff.p2;
    nxt_rcp.pc3 = rcp_ff.pc2;
    nxt_rcp.r3  = rcp_ff.r2 && !rcp_ff.p2;
    a2          = rcp_ff.a1d - mulq(rcp_ff.sq2, rcp_ff.b2);
    nxt_rcp.res3 = {rcp_ff.s2, rcp_ff.e2, a2[40] ? 48'hffff_ffff_ffff : {a2[39:0], 8'h0}};
    if (rcp_ff.p2)
      nxt_rcp.res3 = '0;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rcp_ff <= '0;
    else
      rcp_ff <= nxt_rcp;
  end

  assign rif.done      = rcp_ff.v3;
  assign rif.result    = rcp_ff.res3;
  assign rif.pop_count = rcp_ff.pc3;
  assign rif.range_err = rcp_ff.r3;

  // Checks on pipeline timing and forced outputs
  property p_pop_zero;
    @(posedge clock) disable iff (reset)
    rif.start && rif.pop |-> ##3 (rif.done && rif.result == 64'h0);
  endproperty
  a_pop_zero: assert property (p_pop_zero) else $error("pop output not zero");

  property p_rcp_exp;
    @(posedge clock) disable iff (reset)
    rif.start && !rif.pop |-> ##3 (rif.done && rif.result[62:48] == $past(exp_inv, 3));
  endproperty
  a_rcp_exp: assert property (p_rcp_exp) else $error("reciprocal exponent wrong");
endmodule : fmr_recip

// File: hw/fmr_unit.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Floating-point multiply and reciprocal unit, Avalon-MM slave
// ----------------------------------------------------------------
// Operation
// - Result sign is XOR of signs, exponents add, 48-bit coefficients multiply.
// - Only 48 of the 96 product bits reach the result: bits 95:48, or 94:47 when bit 95 is clear.
// - Overflow keeps calculated coefficient with exponent forced to octal 60000.
// - Overflow sets the saved error flag only when error mode bit set.
// - Exponent at or below octal 17777 zeroes exponent and coefficient, no flag.
// - Shared by scalar and vector opcodes; reservation checked before issue.
// - Mode bits from h bits 1:0 scalar, bits 2:1 vector.
// - 064 pairs 160/161, 065 162/163, 066 164/165, 067 167.
// - Half precision adds rounding at bits 16, 17, then truncates 19 bits.
// - Rounded mode adds two weak rounding bits low in the sum.
// - Iteration adds ones at bits 0 through 46 during summation.
// - Iteration complements final result giving two minus product.
// - No integer multiply here; j and k operands relayed outward.
// - Opcodes 070 and 174 give reciprocal approximation of j operand.
// - First stage: exponent, range error, table, first iteration, pop, control.
// - Second stage squares, delays operand, pre-sums jagged part.
// - Final stage forms second iteration; outputs zero during pop.
// - Reciprocal exponent is ones complement plus one plus one.
// - Reciprocal arrays use Booth recoded multiplication.
// - Reciprocal then half multiply gives a quotient near 29 bits.
module fmr_unit (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [fmr_pkg::FMR_AW-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic      [63:0]                 imul_j_operand,
  output logic      [63:0]                 imul_k_operand,
  output logic                             imul_go,
  output logic                             fp_error_flag,
  output logic                             result_ready
);
  import fmr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fmr_state_type st;
    logic          wreq;
    logic [31:0]   rdata;
    logic [63:0]   opj;
    logic [63:0]   opk;
    logic [63:0]   res;
    logic [8:0]    opcode;
    logic          pop_req;
    logic          ie_mode;
    logic          fp_err;
    logic          ovf;
    logic          rng;
    logic          ready;
    logic [6:0]    popc;
    logic [63:0]   ij;
    logic [63:0]   ik;
    logic          igo;
    logic          rstart;
  } fmr_top_type;

  fmr_top_type top_ff;
  fmr_top_type nxt_top;

  fmr_rcp_if   rif ();

  logic [95:0] prod;
  logic [16:0] mexp;
  logic [47:0] mcoef;
  logic [1:0]  mmode;
  logic        msign;
  logic        mul_ovf;
  logic        mul_unf;
  logic [63:0] mres;
  logic        cmd_take;
  logic        cmd_block;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Mode bits sit one place higher in vector opcodes
  function automatic logic [1:0] mul_mode(input logic [8:0] op);
    return op[6] ? op[2:1] : op[1:0];
  endfunction : mul_mode

  function automatic logic is_mul(input logic [8:0] op);
    return (op >= FMR_OP_S_MUL_LO && op <= FMR_OP_S_MUL_HI)
        || (op >= FMR_OP_V_MUL_LO && op <= FMR_OP_V_MUL_HI && op != FMR_OP_V_IMUL);
  endfunction : is_mul

  // Byte-lane merge for Avalon writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Reciprocal pipeline
  // ----------------------------------------------------------------
  fmr_recip u_recip (
    .clock (clock),
    .reset (reset),
    .rif   (rif.unit)
  );

  // Core drives the pipeline from flip-flops only
  assign rif.start   = top_ff.rstart;
  assign rif.pop     = top_ff.pop_req;
  assign rif.operand = top_ff.opj;

  // ----------------------------------------------------------------
  // Multiply datapath
  // ----------------------------------------------------------------
  // Full product kept for clarity; synthesis prunes the unused low bits
  always_comb
  begin
    mmode = mul_mode(top_ff.opcode);
    msign = top_ff.opj[63] ^ top_ff.opk[63];
    prod  = {48'h0, top_ff.opj[47:0]} * {48'h0, top_ff.opk[47:0]};
    case (mmode)
      FMR_MODE_HALF:  prod = prod + FMR_RND_HALF;
      FMR_MODE_ROUND: prod = prod + FMR_RND_WEAK;
      FMR_MODE_ITER:  prod = prod + FMR_ITER_ONES;
      default:        prod = prod;
    endcase
    mexp = {2'b00, top_ff.opj[62:48]} + {2'b00, top_ff.opk[62:48]}
           - FMR_EXP_BIAS;
    // Normalise: a leading zero costs one exponent step
    if (prod[95])
      mcoef = prod[95:48];
    else
    begin
      mcoef = prod[94:47];
      mexp  = mexp - 17'h1;
    end
    if (mmode == FMR_MODE_HALF)
      mcoef = mcoef & FMR_TRUNC_MASK;
    if (mmode == FMR_MODE_ITER)
      mcoef = ~mcoef;
    mul_unf = mexp[16] || mexp <= {2'b00, FMR_EXP_UNF};
    mul_ovf = !mexp[16] && mexp >= {2'b00, FMR_EXP_OVF};
    if (mul_unf)
      mres = {msign, 63'h0};
    else if (mul_ovf)
      mres = {msign, FMR_EXP_OVF, mcoef};
    else
      mres = {msign, mexp[14:0], mcoef};
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A command write stalls while the unit is reserved
  assign cmd_block = avs_write && avs_address == FMR_ADR_CMD && top_ff.st != FMR_IDLE;
  assign cmd_take  = avs_write && !top_ff.wreq && avs_address == FMR_ADR_CMD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_top        = top_ff;
    nxt_top.igo    = 1'b0;
    nxt_top.rstart = 1'b0;
    nxt_top.ready  = 1'b0;
    // One wait state per access, answer stands one cycle
    nxt_top.wreq   = 1'b1;
    if ((avs_read || avs_write) && top_ff.wreq && !cmd_block)
    begin
      nxt_top.wreq = 1'b0;
      case (avs_address)
        FMR_ADR_J_LO:   nxt_top.rdata = top_ff.opj[31:0];
        FMR_ADR_J_HI:   nxt_top.rdata = top_ff.opj[63:32];
        FMR_ADR_K_LO:   nxt_top.rdata = top_ff.opk[31:0];
        FMR_ADR_K_HI:   nxt_top.rdata = top_ff.opk[63:32];
        FMR_ADR_CMD:    nxt_top.rdata = {22'h0, top_ff.pop_req, top_ff.opcode};
        FMR_ADR_CTRL:   nxt_top.rdata = {31'h0, top_ff.ie_mode};
        FMR_ADR_STATUS: nxt_top.rdata = {28'h0, top_ff.rng, top_ff.ovf, top_ff.fp_err,
                                         top_ff.st != FMR_IDLE};
        FMR_ADR_RES_LO: nxt_top.rdata = top_ff.res[31:0];
        FMR_ADR_RES_HI: nxt_top.rdata = top_ff.res[63:32];
        FMR_ADR_POP:    nxt_top.rdata = {25'h0, top_ff.popc};
        default:        nxt_top.rdata = 32'h0;
      endcase
    end
    // Register writes take effect on the completing edge
    if (avs_write && !top_ff.wreq)
    begin
      case (avs_address)
        FMR_ADR_J_LO: nxt_top.opj[31:0]  = merge(top_ff.opj[31:0], avs_writedata, avs_byteenable);
        FMR_ADR_J_HI: nxt_top.opj[63:32] = merge(top_ff.opj[63:32], avs_writedata, avs_byteenable);
        FMR_ADR_K_LO: nxt_top.opk[31:0]  = merge(top_ff.opk[31:0], avs_writedata, avs_byteenable);
        FMR_ADR_K_HI: nxt_top.opk[63:32] = merge(top_ff.opk[63:32], avs_writedata, avs_byteenable);
        FMR_ADR_CTRL:
        begin
          if (avs_byteenable[0])
            nxt_top.ie_mode = avs_writedata[FMR_CTRL_IE];
        end
        FMR_ADR_STATUS:
        begin
          if (avs_byteenable[0] && avs_writedata[FMR_ST_FPERR])
            nxt_top.fp_err = 1'b0;
        end
        default: nxt_top.fp_err = top_ff.fp_err;
      endcase
    end
    // Command dispatch, only reached when the unit is idle
    if (cmd_take)
    begin
      nxt_top.opcode  = avs_writedata[8:0];
      nxt_top.pop_req = avs_writedata[FMR_CMD_POP];
      if (avs_writedata[8:0] == FMR_OP_V_IMUL)
      begin
        nxt_top.ij  = top_ff.opj;
        nxt_top.ik  = top_ff.opk;
        nxt_top.igo = 1'b1;
      end
      else if (avs_writedata[8:0] == FMR_OP_S_RECIP || avs_writedata[8:0] == FMR_OP_V_RECIP
               || avs_writedata[FMR_CMD_POP])
      begin
        nxt_top.st     = FMR_RECIP;
        nxt_top.rstart = 1'b1;
      end
      else if (is_mul(avs_writedata[8:0]))
        nxt_top.st = FMR_MUL;
    end
    // Operation sequencing
    case (top_ff.st)
      FMR_IDLE: nxt_top.ready = 1'b0;
      FMR_MUL:
      begin
        nxt_top.res   = mres;
        nxt_top.ovf   = mul_ovf;
        nxt_top.rng   = mul_ovf;
        nxt_top.ready = 1'b1;
        nxt_top.st    = FMR_IDLE;
        // Set wins over a software clear in the same cycle
        if (mul_ovf && top_ff.ie_mode)
          nxt_top.fp_err = 1'b1;
      end
      FMR_RECIP:
      begin
        if (rif.done)
        begin
          if (!top_ff.pop_req)
            nxt_top.res = rif.result;
          nxt_top.popc  = rif.pop_count;
          nxt_top.rng   = rif.range_err;
          nxt_top.ovf   = 1'b0;
          nxt_top.ready = 1'b1;
          nxt_top.st    = FMR_IDLE;
        end
      end
      default: nxt_top.st = FMR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      top_ff <= '{st: FMR_IDLE, wreq: FMR_WREQ_RST, default: '0};
    else
      top_ff <= nxt_top;
  end

  assign avs_readdata    = top_ff.rdata;
  assign avs_waitrequest = top_ff.wreq;
  assign imul_j_operand  = top_ff.ij;
  assign imul_k_operand  = top_ff.ik;
  assign imul_go         = top_ff.igo;
  assign fp_error_flag   = top_ff.fp_err;
  assign result_ready    = top_ff.ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reserve;
    @(posedge clock) disable iff (reset)
    cmd_block |=> avs_waitrequest;
  endproperty
  a_reserve: assert property (p_reserve) else $error("command taken while busy");

  property p_sign;
    @(posedge clock) disable iff (reset)
    top_ff.st == FMR_MUL |=> result_ready && top_ff.res[63] == $past(msign);
  endproperty
  a_sign: assert property (p_sign) else $error("product sign wrong");

  property p_ovf_exp;
    @(posedge clock) disable iff (reset)
    top_ff.st == FMR_MUL && mul_ovf |=> top_ff.res[62:48] == FMR_EXP_OVF && top_ff.ovf;
  endproperty
  a_ovf_exp: assert property (p_ovf_exp) else $error("overflow exponent wrong");

  property p_ovf_flag;
    @(posedge clock) disable iff (reset)
    top_ff.st == FMR_MUL && mul_ovf && top_ff.ie_mode |=> fp_error_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("error flag not set");

  property p_unf;
    @(posedge clock) disable iff (reset)
    top_ff.st == FMR_MUL && mul_unf && !top_ff.fp_err |=>
      top_ff.res[62:0] == 63'h0 && !top_ff.ovf && !fp_error_flag;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not zeroed");

  property p_trunc;
    @(posedge clock) disable iff (reset)
    top_ff.st == FMR_MUL && mmode == FMR_MODE_HALF && !mul_unf |=> top_ff.res[18:0] == 19'h0;
  endproperty
  a_trunc: assert property (p_trunc) else $error("half product not truncated");

  property p_relay;
    @(posedge clock) disable iff (reset)
    cmd_take && avs_writedata[8:0] == FMR_OP_V_IMUL |=>
      imul_go && imul_j_operand == $past(top_ff.opj) ##1 !imul_go;
  endproperty
  a_relay: assert property (p_relay) else $error("integer operands not relayed");

  property p_answer;
    @(posedge clock) disable iff (reset)
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("answer held too long");
endmodule : fmr_unit

// File: test/fmr_imul_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Integer multiply stand-in
// ----------------------------------------------------------------
module fmr_imul_model (
  input  wire logic        clock,
  input  wire logic        imul_go,
  input  wire logic [63:0] imul_j_operand,
  input  wire logic [63:0] imul_k_operand,
  output logic      [63:0] got_j,
  output logic      [63:0] got_k,
  output int               go_cnt
);
  initial go_cnt = 0;
  // Latch only on the go pulse; operands are not trusted outside it
  always @(posedge clock)
    if (imul_go === 1'b1)
    begin
      got_j  <= imul_j_operand;
      got_k  <= imul_k_operand;
      go_cnt <= go_cnt + 1;
    end
endmodule : fmr_imul_model

// File: test/fp_multiply_reciprocal_unit_bench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module fp_multiply_reciprocal_unit_bench;
  import fmr_pkg::*;
  logic        clock, reset, avs_read, avs_write, avs_waitrequest;
  logic        imul_go, fp_error_flag, result_ready;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [63:0] imul_j_operand, imul_k_operand, got_j, got_k, a, b, r, r0;
  logic [8:0]  ops [11] = '{9'h034, 9'h035, 9'h036, 9'h037, 9'h070, 9'h071, 9'h072,
                            9'h073, 9'h074, 9'h075, 9'h077};
  int          error_cnt = 0, cmp_count = 0, cyc = 0, go_cnt, seed = 32'hfad41e4a;
  int          t0, dexp;
  logic [95:0] p96, t96, e96;
  fmr_unit uut (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .imul_j_operand(imul_j_operand), .imul_k_operand(imul_k_operand), .imul_go(imul_go),
    .fp_error_flag(fp_error_flag), .result_ready(result_ready));
  fmr_imul_model far (.clock(clock), .imul_go(imul_go), .imul_j_operand(imul_j_operand),
    .imul_k_operand(imul_k_operand), .got_j(got_j), .got_k(got_k), .go_cnt(go_cnt));
  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // Cycle ceiling; a hang counts as a mismatch
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Avalon access: held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [5:0] ad, input logic [31:0] d,
                     output logic [31:0] qq);
    @(posedge clock);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    qq = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask : bus
  task automatic run(input logic [63:0] x, y, input logic [9:0] cmd, input logic wt,
                     output logic [63:0] res);
    int n;
    bus(0, FMR_ADR_J_LO, x[31:0], q);
    bus(0, FMR_ADR_J_HI, x[63:32], q);
    bus(0, FMR_ADR_K_LO, y[31:0], q);
    bus(0, FMR_ADR_K_HI, y[63:32], q);
    bus(0, FMR_ADR_CMD, {22'h0, cmd}, q);
    n = 0;
    while (wt && result_ready !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    if (wt) chk("ready", 1, {63'h0, result_ready});
    bus(1, FMR_ADR_RES_LO, 0, res[31:0]);
    bus(1, FMR_ADR_RES_HI, 0, res[63:32]);
  endtask : run
  // Normalised random operand, exponent just above the given base
  function automatic logic [63:0] rnd(input logic [14:0] eb);
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    v[62:48] = eb + {6'h0, v[8:0]};
    v[47] = 1'b1;
    return v;
  endfunction : rnd
  // Reference product with rounding, iteration and range handling
  function automatic logic [63:0] fmul(input logic [63:0] x, y, input logic [8:0] op);
    logic [1:0]  m;
    logic [95:0] p;
    logic [16:0] e;
    logic [47:0] c;
    m = (op < 9'h040) ? op[1:0] : op[2:1];
    p = {48'h0, x[47:0]} * {48'h0, y[47:0]};
    if (m == 2'h1) p = p + (96'h3 << 64);
    if (m == 2'h2) p = p + (96'h3 << 45);
    if (m == 2'h3) p = p + 96'h7fff_ffff_ffff;
    e = {2'h0, x[62:48]} + {2'h0, y[62:48]} - 17'h04000;
    if (!p[95])
    begin
      p = p << 1;
      e = e - 17'h1;
    end
    c = p[95:48];
    if (m == 2'h1) c[18:0] = 19'h0;
    if (m == 2'h3) c = ~c;
    if (e[16] || e <= 17'h01fff) return {x[63] ^ y[63], 63'h0};
    if (e >= 17'h06000) e = 17'h06000;
    return {x[63] ^ y[63], e[14:0], c};
  endfunction : fmul
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Main sequence
  initial
  begin
    reset = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    repeat (20) @(posedge clock);
    reset <= 0;
    chk("wait_idle", 1, {63'h0, avs_waitrequest});
    chk("flag_rst", 0, {63'h0, fp_error_flag});
    bus(1, 6'h3c, 0, q);
    chk("unmapped", 0, {32'h0, q});
    $display("test reset done");
    for (int k = 0; k < 22; k++)
    begin
      a = rnd(15'h3f00);
      b = rnd(15'h3f00);
      run(a, b, {1'b0, ops[k % 11]}, 1, r);
      chk("product", fmul(a, b, ops[k % 11]), r);
    end
    $display("test products done");
    for (int ie = 0; ie < 2; ie++)
    begin
      bus(0, FMR_ADR_CTRL, ie, q);
      a = rnd(15'h5800);
      b = rnd(15'h4900);
      run(a, b, 10'h034, 1, r);
      chk("ovf_res", fmul(a, b, 9'h034), r);
      chk("ovf_flag", ie, {63'h0, fp_error_flag});
      a = rnd(15'h2000);
      b = rnd(15'h1e00);
      run(a, b, 10'h071, 1, r);
      chk("unf_res", {a[63] ^ b[63], 63'h0}, r);
      chk("unf_flag", ie, {63'h0, fp_error_flag});
      bus(0, FMR_ADR_STATUS, 32'h2, q);
    end
    $display("test range done");
    for (int k = 0; k < 2; k++)
    begin
      b = rnd(15'h3f00);
      run(b, a, k ? 10'h07c : 10'h038, 1, r);
      chk("rcp_exp", 64'(15'(~b[62:48] + 15'h2)), 64'(r[62:48]));
    end
    r0 = r;
    run(a, b, 10'h200, 1, r);
    chk("pop_res", r0, r);
    bus(1, FMR_ADR_POP, 0, q);
    chk("pop", 64'($countones(a)), {32'h0, q});
    // A command written while the unit is busy stalls until it is idle
    bus(0, FMR_ADR_CMD, {23'h0, FMR_OP_S_RECIP}, q);
    t0 = cyc;
    bus(0, FMR_ADR_CMD, {23'h0, FMR_OP_S_RECIP}, q);
    chk("reserve", 6, cyc - t0);
    // Reciprocal then half multiply must give a quotient good to 29 bits
    a = rnd(15'h3f00);
    run(b, a, 10'h038, 1, r);
    run(a, r, 10'h035, 1, r);
    dexp = int'(a[62:48]) - int'(r[62:48]) - int'(b[62:48]) + 16'h4000;
    p96  = {48'h0, r[47:0]} * {48'h0, b[47:0]};
    t96  = {48'h0, a[47:0]} << (48 + dexp);
    e96  = (p96 > t96) ? p96 - t96 : t96 - p96;
    chk("quot29", 1, {63'h0, (dexp == 0 || dexp == -1) && e96 < (t96 >> 28)});
    $display("test reciprocal done");
    run(a, b, {1'b0, FMR_OP_V_IMUL}, 0, r);
    chk("imul_j", a, got_j);
    chk("imul_k", b, got_k);
    chk("imul_go", 1, go_cnt);
    $display("test relay done");
    summarize();
  end
endmodule : fp_multiply_reciprocal_unit_bench
